// File: include/ias_pkg.sv
// constants for the isolated adc sequencer: register map, control fields, timing
// assumes a 125 MHz core clock and IndustryPack-style byte-addressed io space
package ias_pkg;
   // io space byte offsets
   localparam logic [5:0] OFS_CONTROL = 6'h00;
   localparam logic [5:0] OFS_RESULT  = 6'h02;
   localparam logic [5:0] OFS_STATUS  = 6'h05;
   localparam logic [5:0] OFS_START   = 6'h07;
   localparam logic [5:0] OFS_VECTOR  = 6'h09;
   // control register fields
   localparam int CTL_IRQ_ALLOW  = 9;
   localparam int CTL_RESULT_LAG = 8;
   localparam int CTL_AUTO_SETTLE = 7;
   localparam int CTL_AMP_HI     = 6;
   localparam int CTL_AMP_LO     = 5;
   localparam int CTL_PAIRING    = 4;
   localparam int CTL_CHAN_HI    = 3;
   localparam int CTL_WIDTH      = 10;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [6:0]  VECTOR_RESET  = 7'h00;
   localparam logic [15:0] RESULT_RESET  = 16'h0000;
   // status bits
   localparam int STA_CONV_BUSY   = 1;
   localparam int STA_SETTLE_BUSY = 0;
   // timing
   localparam int CLK_MHZ        = 125;
   localparam int SETTLE_US      = 10;
   localparam int SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;
   localparam int CONVERT_CYCLES = 1000;
endpackage

// File: rtl/ias_sequencer.sv
// control logic of a 16-input 12-bit isolated converter seen through IP io space
// assumes byte-wide io strobes synchronous to core_clk, a converter core with start/done handshake
//
// Contract
// - settling interval of about 10 us after every control write, same for all gains.
// - control bits 6:5 choose amplifier gain, 00 is unity.
// - control bit 4 zero gives 16 single inputs; one pairs 9-16 with 1-8.
// - control bits 3:0 select channel; differential uses codes 0 to 7 only.
// - result sits in upper twelve bits, low four bits zero.
// - bipolar parts read result as two's complement.
// - unipolar parts read result as straight binary.
// - result valid only while conversion busy reads zero.
// - status bit 1 is conversion busy; in auto mode covers settling too.
// - status bit 0 is settling busy; bits 7:2 undefined, read zero.
// - any write to convert start offset 0x07 launches conversion at once; the code takes it on the high byte lane only and ignores it with control bit 7 set.
// - convert start writes during conversion busy are ignored.
// - settle-done and data-ready raise separate requests, cleared by acknowledge cycle.
// - vector bits 7:1 are software loaded, reset zero, readable.
// - acknowledge returns vector bit 0 one for settle-done, zero for data-ready.
// - ordinary io read of vector always shows bit 0 zero.
// - settle-done request on falling settling busy, normal mode only.
// - data-ready request on falling conversion busy.
// - reset clears all converter registers.
// - control bit 9 low masks both interrupt requests.
// - auto mode: control write starts sequence, conversion held until settled.
// - lag mode loads previous result while current conversion runs.
`timescale 1ns/1ns
module ias_sequencer #(
   parameter int SETTLE_CYCLES  = ias_pkg::SETTLE_CYCLES,
   parameter int CONVERT_CYCLES = ias_pkg::CONVERT_CYCLES
) (
   input  wire logic        core_clk,       // 125 MHz clock
   input  wire logic        nrst,           // synchronous reset, low active
   input  wire logic        io_sel,         // io space access strobe, one cycle
   input  wire logic        io_we,          // 1 write, 0 read
   input  wire logic [5:0]  io_addr,        // byte address
   input  wire logic [15:0] io_wdata,       // write data
   input  wire logic [1:0]  io_be,          // byte enables, [1] high byte, [0] low byte
   output logic      [15:0] io_rdata,       // read data, registered
   output logic             io_ack,         // access done, one cycle
   input  wire logic        int_ack,        // interrupt acknowledge cycle strobe
   output logic      [7:0]  int_vec,        // vector during acknowledge, registered
   output logic             int_ack_done,   // acknowledge answered, one cycle
   output logic             intreq0_n,      // data-ready request, low active
   output logic             intreq1_n,      // settle-done request, low active
   output logic      [1:0]  amp_sel,        // gain code to analog front end
   output logic             pair_sel,       // differential pairing to mux
   output logic      [3:0]  chan_sel,       // channel code to mux
   output logic             adc_start,      // converter start pulse
   input  wire logic        adc_done,       // converter done pulse
   input  wire logic [11:0] adc_data        // converter sample, valid with adc_done
);
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SETTLE = 3'b010,
      ST_CONV   = 3'b100
   } ias_conv_t;

   // word decode: an 8-bit register at an odd address shares its word
   function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
      hit = (a[5:1] == ofs[5:1]);
   endfunction

   logic [15:0] control_r;
   logic [15:0] result_r;
   logic [15:0] lag_r;
   logic [6:0]  vector_r;
   logic [15:0] settle_cnt_r;
   logic [15:0] conv_cnt_r;
   ias_conv_t   conv_st_r;
   logic        auto_pend_r;
   logic        settle_busy_d_r;
   logic        conv_busy_d_r;
   logic        req_settle_r;
   logic        req_data_r;

   logic wr_control;
   logic wr_start;
   logic wr_vector;
   logic wr_result;
   logic settle_busy;
   logic conv_busy;
   logic settle_fall;
   logic conv_fall;
   logic auto_go;
   logic ack_settle;
   logic ack_data;
   logic [15:0] sample;
   logic [7:0]  status_byte;

   assign wr_control = io_sel && io_we && hit(io_addr, ias_pkg::OFS_CONTROL);
   assign wr_start   = io_sel && io_we && hit(io_addr, ias_pkg::OFS_START) && io_be[1];
   assign wr_vector  = io_sel && io_we && hit(io_addr, ias_pkg::OFS_VECTOR) && io_be[1];
   assign wr_result  = io_sel && io_we && hit(io_addr, ias_pkg::OFS_RESULT);
   assign settle_busy = (settle_cnt_r != 16'h0000);
   assign sample      = {adc_data, 4'h0};
   // in auto mode settling already counts as conversion activity
   assign conv_busy   = (conv_st_r == ST_CONV) || (conv_st_r == ST_SETTLE);
   assign status_byte = {6'h00, conv_busy, settle_busy};
   assign settle_fall = settle_busy_d_r && !settle_busy;
   assign conv_fall   = conv_busy_d_r && !conv_busy;
   assign auto_go     = auto_pend_r && !settle_busy;

   assign amp_sel  = control_r[ias_pkg::CTL_AMP_HI:ias_pkg::CTL_AMP_LO];
   assign pair_sel = control_r[ias_pkg::CTL_PAIRING];
   // high code bit dropped when pairing so codes 8-15 alias to codes 0-7
   assign chan_sel = {control_r[ias_pkg::CTL_CHAN_HI] & ~control_r[ias_pkg::CTL_PAIRING], control_r[2:0]};

   // control register; the upper six bits are not stored and read zero
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         control_r <= ias_pkg::CONTROL_RESET;
      end else if (wr_control) begin
         if (io_be[0]) control_r[7:0] <= io_wdata[7:0];
         if (io_be[1]) control_r[15:8] <= {6'h00, io_wdata[9:8]};
      end
   end

   // settling down-counter
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         settle_cnt_r <= 16'h0000;
      end else if (wr_control) begin
         settle_cnt_r <= 16'(SETTLE_CYCLES);
      end else if (settle_busy) begin
         settle_cnt_r <= settle_cnt_r - 16'h0001;
      end
   end

   // auto mode pending start
   // kept until the launch, so an auto write during a running conversion is not lost
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         auto_pend_r <= 1'b0;
      end else if (wr_control) begin
         auto_pend_r <= io_be[0] && io_wdata[ias_pkg::CTL_AUTO_SETTLE];
      end else if (auto_go && conv_st_r == ST_SETTLE) begin
         auto_pend_r <= 1'b0;
      end
   end

   // conversion sequencer
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         conv_st_r  <= ST_IDLE;
         conv_cnt_r <= 16'h0000;
         adc_start  <= 1'b0;
      end else begin
         adc_start <= 1'b0;
         case (conv_st_r)
            ST_IDLE: begin
               if (wr_control) begin
                  if (io_be[0] && io_wdata[ias_pkg::CTL_AUTO_SETTLE]) begin
                     conv_st_r <= ST_SETTLE;
                  end
               end else if (auto_pend_r) begin
                  conv_st_r <= ST_SETTLE;
               end else if (wr_start && !control_r[ias_pkg::CTL_AUTO_SETTLE]) begin
                  conv_st_r  <= ST_CONV;
                  conv_cnt_r <= 16'(CONVERT_CYCLES);
                  adc_start  <= 1'b1;
               end
            end
            ST_SETTLE: begin
               if (auto_go) begin
                  conv_st_r  <= ST_CONV;
                  conv_cnt_r <= 16'(CONVERT_CYCLES);
                  adc_start  <= 1'b1;
               end else if (!auto_pend_r) begin
                  conv_st_r <= ST_IDLE; // a normal-mode write cancelled the auto start
               end
            end
            ST_CONV: begin
               // start writes fall through untouched here
               if (adc_done || conv_cnt_r == 16'h0001) begin
                  conv_st_r <= ST_IDLE;
               end
               conv_cnt_r <= conv_cnt_r - 16'h0001;
            end
            default: conv_st_r <= ST_IDLE;
         endcase
      end
   end

   // result register: lag load at start, fresh sample at done, host write
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         result_r <= ias_pkg::RESULT_RESET;
      end else if (adc_start && control_r[ias_pkg::CTL_RESULT_LAG]) begin
         result_r <= lag_r;
      end else if (adc_done && conv_st_r == ST_CONV) begin
         if (!control_r[ias_pkg::CTL_RESULT_LAG]) result_r <= sample;
      end else if (wr_result) begin
         result_r <= {io_wdata[15:4], 4'h0};
      end
   end

   // previous sample kept for lag mode
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         lag_r <= ias_pkg::RESULT_RESET;
      end else if (adc_done && conv_st_r == ST_CONV) begin
         lag_r <= sample;
      end
   end

   // vector register
   // vector is written on the high byte lane of its odd address, read back on the low lane
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         vector_r <= ias_pkg::VECTOR_RESET;
      end else if (wr_vector) begin
         vector_r <= io_wdata[15:9];
      end
   end

   // edge detectors
   // both start at the idle level of their flag, so no false edge follows reset
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         settle_busy_d_r <= 1'b0;
         conv_busy_d_r   <= 1'b0;
      end else begin
         settle_busy_d_r <= settle_busy;
         conv_busy_d_r   <= conv_busy;
      end
   end

   // settle-done goes first on acknowledge, data-ready next
   assign ack_settle = int_ack && req_settle_r;
   assign ack_data   = int_ack && !req_settle_r && req_data_r;

   // settle-done request: set wins over the acknowledge clear
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         req_settle_r <= 1'b0;
      end else if (settle_fall && !control_r[ias_pkg::CTL_AUTO_SETTLE] && control_r[ias_pkg::CTL_IRQ_ALLOW]) begin
         req_settle_r <= 1'b1;
      end else if (ack_settle || !control_r[ias_pkg::CTL_IRQ_ALLOW]) begin
         req_settle_r <= 1'b0;
      end
   end

   // data-ready request: set wins over the acknowledge clear
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         req_data_r <= 1'b0;
      end else if (conv_fall && control_r[ias_pkg::CTL_IRQ_ALLOW]) begin
         req_data_r <= 1'b1;
      end else if (ack_data || !control_r[ias_pkg::CTL_IRQ_ALLOW]) begin
         req_data_r <= 1'b0;
      end
   end

   assign intreq1_n = ~req_settle_r;
   assign intreq0_n = ~req_data_r;

   // vector answer, bit 0 names the source being served
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         int_vec <= 8'h00;
      end else if (int_ack) begin
         int_vec <= {vector_r, ack_settle};
      end
   end

   // acknowledge answered one cycle after its strobe
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         int_ack_done <= 1'b0;
      end else begin
         int_ack_done <= int_ack;
      end
   end

   // io read path, data stands until the next read
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         io_rdata <= 16'h0000;
      end else if (io_sel && !io_we) begin
         case (io_addr[5:1])
            ias_pkg::OFS_CONTROL[5:1]: io_rdata <= control_r;
            ias_pkg::OFS_RESULT[5:1]:  io_rdata <= result_r;
            // undefined status bits read zero
            ias_pkg::OFS_STATUS[5:1]:  io_rdata <= {8'h00, status_byte};
            ias_pkg::OFS_VECTOR[5:1]:  io_rdata <= {8'h00, vector_r, 1'b0};
            default:                   io_rdata <= 16'h0000;
         endcase
      end
   end

   // every access is answered one cycle after its strobe
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         io_ack <= 1'b0;
      end else begin
         io_ack <= io_sel;
      end
   end
endmodule // ias_sequencer

// File: verif/ias_monitor.sv
// checker on the sequencer ports: io reads, requests, converter starts
// assumes it is bound onto ias_sequencer, one clock, synchronous low reset
`timescale 1ns/1ns
module ias_monitor #(
   parameter int SETTLE_CYCLES = 20
) (
   input wire logic        core_clk,     // clock
   input wire logic        nrst,         // reset
   input wire logic        io_sel,       // strobe
   input wire logic        io_we,        // write
   input wire logic [5:0]  io_addr,      // address
   input wire logic [15:0] io_wdata,     // write data
   input wire logic [1:0]  io_be,        // lanes
   input wire logic [15:0] io_rdata,     // read data
   input wire logic        int_ack,      // ack cycle
   input wire logic [7:0]  int_vec,      // vector
   input wire logic        int_ack_done, // ack answer
   input wire logic        intreq0_n,    // data request
   input wire logic        intreq1_n,    // settle request
   input wire logic        adc_start,    // start
   input wire logic        adc_done      // done
);
   localparam int S_LO = SETTLE_CYCLES;
   localparam int S_HI = SETTLE_CYCLES + 3;
   localparam int A_LO = SETTLE_CYCLES - 9;
   logic       allow_r;
   logic       auto_r;
   logic       busy_r;
   logic [6:0] vec_r;
   wire logic  wr_ctl = io_sel && io_we && io_addr == ias_pkg::OFS_CONTROL;
   wire logic  wr_go  = io_sel && io_we && io_addr == ias_pkg::OFS_START && io_be[1];
   wire logic  rd_res = io_sel && !io_we && io_addr == ias_pkg::OFS_RESULT;
   wire logic  rd_vec = io_sel && !io_we && io_addr == ias_pkg::OFS_VECTOR;
   wire logic  wr_vec = io_sel && io_we && io_addr == ias_pkg::OFS_VECTOR && io_be[1];
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         allow_r <= 1'b0;
         auto_r  <= 1'b0;
      end else if (wr_ctl) begin
         if (io_be[1]) allow_r <= io_wdata[9];
         if (io_be[0]) auto_r <= io_wdata[7];
      end
   end
   always_ff @(posedge core_clk) begin
      if (!nrst) vec_r <= 7'h00;
      else if (wr_vec) vec_r <= io_wdata[15:9];
   end
   // converter busy as seen from the start and done pulses
   always_ff @(posedge core_clk) begin
      if (!nrst) busy_r <= 1'b0;
      else if (adc_start) busy_r <= 1'b1;
      else if (adc_done) busy_r <= 1'b0;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   req_reset_a: assert property ($rose(nrst) |-> intreq0_n && intreq1_n && !adc_start)
      else $error("outputs not idle after reset");
   res_nibble_a: assert property ($past(rd_res) |-> io_rdata[3:0] == 4'h0)
      else $error("result low nibble not zero");
   vec_read_a: assert property ($past(rd_vec) |-> io_rdata[7:0] == {vec_r, 1'b0})
      else $error("vector io read wrong");
   start_now_a: assert property (wr_go && !busy_r && !adc_start && !auto_r |=> adc_start)
      else $error("start write did not launch");
   no_restart_a: assert property (adc_start |-> !busy_r)
      else $error("start during conversion");
   data_req_a: assert property (adc_done && allow_r |-> ##2 !intreq0_n)
      else $error("data request missing");
   irq_mask_a: assert property (!allow_r && !$past(allow_r) |-> intreq0_n && intreq1_n)
      else $error("request while masked");
   settle_req_a: assert property (wr_ctl && io_be == 2'h3 && io_wdata[9] && !io_wdata[7]
      |-> ##[S_LO:S_HI] !intreq1_n) else $error("settle request missing");
   auto_start_a: assert property (wr_ctl && io_be[0] && io_wdata[7]
      |=> (!adc_start) [*8] ##[A_LO:S_HI] adc_start) else $error("auto start wrong");
   ack_settle_a: assert property (int_ack && !intreq1_n |=> int_ack_done && int_vec == {vec_r, 1'b1})
      else $error("settle vector wrong");
   ack_data_a: assert property (int_ack && intreq1_n && !intreq0_n |=> int_ack_done && int_vec == {vec_r, 1'b0})
      else $error("data vector wrong");
   cover property (adc_start && auto_r);
   cover property (int_ack && !intreq1_n);
   cover property (wr_go && busy_r);
endmodule // ias_monitor

bind ias_sequencer ias_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) mon (
   .core_clk(core_clk), .nrst(nrst), .io_sel(io_sel), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
   .io_be(io_be), .io_rdata(io_rdata), .int_ack(int_ack), .int_vec(int_vec), .int_ack_done(int_ack_done),
   .intreq0_n(intreq0_n), .intreq1_n(intreq1_n), .adc_start(adc_start), .adc_done(adc_done));

// File: verif/ias_adc_model.sv
// converter core stand-in: answers each start pulse after a fixed latency
// assumes start is a one-cycle pulse on the core clock
`timescale 1ns/1ns
module ias_adc_model #(
   parameter int LAT = 5
) (
   input wire logic        core_clk,  // clock
   input wire logic        adc_start, // start pulse
   input wire logic [11:0] sample,    // value to return
   output logic            adc_done,  // done pulse
   output logic     [11:0] adc_data   // valid with done
);
   int cnt_r = 0;
   always_ff @(posedge core_clk) begin
      if (adc_start) cnt_r <= LAT;
      else if (cnt_r > 0) cnt_r <= cnt_r - 1;
   end
   assign adc_done = cnt_r == 1;
   // inverted outside done so a stale sample cannot pass
   assign adc_data = adc_done ? sample : ~sample;
endmodule // ias_adc_model

// File: verif/tb.sv
// bench for the sequencer: host io traffic, converter stand-in, request checks
// assumes the monitor is bound and the converter answers inside the timeout
`timescale 1ns/1ns
module tb;
   logic        core_clk = 0, nrst = 0, io_sel = 0, io_we = 0, int_ack = 0;
   logic        io_ack, int_ack_done, intreq0_n, intreq1_n, pair_sel, adc_start, adc_done;
   logic [5:0]  io_addr = 6'h00;
   logic [15:0] io_wdata = 16'h0000, io_rdata, rv;
   logic [1:0]  io_be = 2'h0, amp_sel;
   logic [7:0]  int_vec;
   logic [3:0]  chan_sel;
   logic [11:0] adc_data, sample = 12'h000, prev;
   logic [31:0] seed = 32'he589;
   logic [5:0]  ra [5] = '{6'h00, 6'h02, 6'h05, 6'h09, 6'h0b};
   logic [11:0] cd [5] = '{12'h7ff, 12'h000, 12'hfff, 12'h800, 12'h5a3};
   int          mismatches = 0, n_tests = 0;
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   ias_sequencer #(.SETTLE_CYCLES(20), .CONVERT_CYCLES(10)) dut (.core_clk(core_clk), .nrst(nrst),
      .io_sel(io_sel), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata), .io_be(io_be),
      .io_rdata(io_rdata), .io_ack(io_ack), .int_ack(int_ack), .int_vec(int_vec), .int_ack_done(int_ack_done),
      .intreq0_n(intreq0_n), .intreq1_n(intreq1_n), .amp_sel(amp_sel), .pair_sel(pair_sel),
      .chan_sel(chan_sel), .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data));
   ias_adc_model m0 (.core_clk(core_clk), .adc_start(adc_start), .sample(sample), .adc_done(adc_done),
      .adc_data(adc_data));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [3:0] chan_exp(input logic [15:0] c);
      return c[4] ? {1'b0, c[2:0]} : c[3:0];
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic acc(input logic we, input logic [5:0] a, input logic [15:0] d, input logic [1:0] be);
      io_sel = 1;
      io_we = we;
      io_addr = a;
      io_wdata = d;
      io_be = be;
      @(posedge core_clk) #1;
      io_sel = 0;
      for (int i = 0; i < 4 && io_ack !== 1'b1; i++) @(posedge core_clk) #1;
      if (io_ack !== 1'b1) begin
         mismatches++;
         end_sim;
      end
      rv = io_rdata;
      @(posedge core_clk) #1;
   endtask
   task automatic idle;
      for (int i = 0; i < 100; i++) begin
         acc(0, ias_pkg::OFS_STATUS, 16'h0000, 2'h2);
         if (rv[1:0] === 2'b00) return;
      end
      mismatches++;
      end_sim;
   endtask
   task automatic iack(input logic [7:0] exp);
      int_ack = 1;
      @(posedge core_clk) #1;
      int_ack = 0;
      chk({int_ack_done, 7'h00, int_vec}, {1'b1, 7'h00, exp});
      @(posedge core_clk) #1;
   endtask
   initial begin
      logic [15:0] c;
      repeat (20) @(posedge core_clk);
      #1 nrst = 1;
      foreach (ra[i]) begin
         acc(0, ra[i], 16'h0000, 2'h3);
         chk(rv, 16'h0000);
      end
      $display("test reset done");
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         c = k ? {9'h000, seed[6:0]} : 16'h001f;
         acc(1, ias_pkg::OFS_CONTROL, c, 2'h3);
         chk(16'({amp_sel, pair_sel, chan_sel}), 16'({c[6:5], c[4], chan_exp(c)}));
         idle;
      end
      $display("test fields done");
      acc(1, ias_pkg::OFS_VECTOR, 16'h6100, 2'h2);
      acc(0, ias_pkg::OFS_VECTOR, 16'h0000, 2'h3);
      chk(16'(rv[7:0]), 16'h0060);
      seed = xs(seed);
      cd[4] = seed[11:0];
      foreach (cd[i]) begin
         seed = xs(seed);
         sample = cd[i];
         acc(1, ias_pkg::OFS_CONTROL, {12'h020, seed[3:0]}, 2'h3);
         idle;
         chk(16'(intreq1_n), 16'h0000);
         iack(8'h61);
         acc(1, ias_pkg::OFS_START, 16'h0000, 2'h2);
         acc(1, ias_pkg::OFS_START, 16'h0000, 2'h2);
         idle;
         acc(0, ias_pkg::OFS_RESULT, 16'h0000, 2'h3);
         chk(rv, {cd[i], 4'h0});
         chk(16'(intreq0_n), 16'h0000);
         iack(8'h60);
      end
      $display("test normal done");
      sample = 12'h123;
      acc(1, ias_pkg::OFS_CONTROL, 16'h0280, 2'h3);
      acc(0, ias_pkg::OFS_STATUS, 16'h0000, 2'h2);
      chk(16'(rv[1]), 16'h0001);
      idle;
      chk(16'({intreq1_n, intreq0_n}), 16'h0002);
      iack(8'h60);
      acc(0, ias_pkg::OFS_RESULT, 16'h0000, 2'h3);
      chk(rv, 16'h1230);
      $display("test auto done");
      prev = 12'h123;
      acc(1, ias_pkg::OFS_CONTROL, 16'h0100, 2'h3);
      idle;
      repeat (3) begin
         seed = xs(seed);
         sample = seed[11:0];
         acc(1, ias_pkg::OFS_START, 16'h0000, 2'h2);
         idle;
         acc(0, ias_pkg::OFS_RESULT, 16'h0000, 2'h3);
         chk(rv, {prev, 4'h0});
         chk(16'({intreq1_n, intreq0_n}), 16'h0003);
         prev = sample;
      end
      acc(1, ias_pkg::OFS_RESULT, 16'habcd, 2'h3);
      acc(0, ias_pkg::OFS_RESULT, 16'h0000, 2'h3);
      chk(rv, 16'habc0);
      $display("test lag done");
      nrst = 0;
      repeat (2) @(posedge core_clk);
      #1 nrst = 1;
      acc(0, ias_pkg::OFS_CONTROL, 16'h0000, 2'h3);
      chk(rv, 16'h0000);
      acc(0, ias_pkg::OFS_RESULT, 16'h0000, 2'h3);
      chk(rv, 16'h0000);
      $display("test rerun reset done");
      end_sim;
   end
endmodule // tb
